// *** shared/anxp_consts.svh ***
// Offsets, field positions, reset values and the extended-control write mask of the next-page exchange block
`ifndef ANXP_CONSTS_SVH
`define ANXP_CONSTS_SVH
`define ANXP_OFF_EXPANSION 5'h06
`define ANXP_OFF_NP_TX 5'h07
`define ANXP_OFF_RECEIVED_PAGE_WORD 5'h08
`define ANXP_OFF_EXT_CTL 5'h0D
`define ANXP_OFF_IRQ_STS 5'h1E
`define ANXP_OFF_IRQ_MASK 5'h1F
`define ANXP_RST_NP_TX 16'h2001
`define ANXP_RST_RECEIVED_PAGE_WORD 16'h0000
`define ANXP_RST_EXT_CTL 16'h0000
`define ANXP_BIT_NEXT_PAGE 15
`define ANXP_BIT_RSVD 14
`define ANXP_BIT_MSG_PAGE 13
`define ANXP_BIT_COMPLY 12
`define ANXP_BIT_TOGGLE 11
`define ANXP_EXP_BIT_PAGE_RX 1
`define ANXP_EXP_BIT_AN_ABLE 0
`define ANXP_EXP_BIT_STORE_SEL 5
`define ANXP_EXP_BIT_LOC_ABLE 6
`define ANXP_EXT_CTL_MASK 16'hC01F
`endif

// *** shared/anxp_pkg.sv ***
// Types of the next-page exchange block
package anxp_pkg;
    typedef struct packed {
        logic write;
        logic read;
        logic [4:0] addr;
        logic [15:0] wdata;
    } anxp_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } anxp_page_t;

    typedef struct packed {
        logic page_received;
        logic tx_page_taken;
    } anxp_irq_t;
endpackage

// *** rtl/anxp_next_page.sv ***
// Next-page exchange registers of the auto-negotiation function
//==========================================================
// Function
// - Expansion bit 1 is set when a new partner page arrived, else 0.
// - Expansion bit 0 reports partner auto-negotiation capability, 1 meaning capable.
// - Hardware computes the toggle bit 11 of the outgoing word.
// - Received 16-bit partner next page readable at offset 0x08, read-only.
// - Received page register is accessed only as one 16-bit word.
// - Expansion bit 5 says partner next pages land in the received register.
`include "anxp_consts.svh"

module anxp_next_page
    import anxp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic rx_page_valid,
    input wire logic [15:0] rx_page_word,
    input wire logic partner_negotiation_capable,
    input wire logic tx_page_taken,
    output logic [15:0] tx_page_word,
    output logic irq
);

    //==========================================================
    // Input synchronisers
    logic [1:0] able_sync_r;
    logic [1:0] taken_sync_r;
    logic [1:0] rxv_sync_r;
    logic [15:0] rxw_s1_r;
    logic [15:0] rxw_s2_r;
    logic taken_prev_r;
    logic rxv_prev_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            able_sync_r <= 2'h0;
            taken_sync_r <= 2'h0;
            rxv_sync_r <= 2'h0;
            rxw_s1_r <= 16'h0000;
            rxw_s2_r <= 16'h0000;
            taken_prev_r <= 1'b0;
            rxv_prev_r <= 1'b0;
        end else begin
            able_sync_r <= {able_sync_r[0], partner_negotiation_capable};
            taken_sync_r <= {taken_sync_r[0], tx_page_taken};
            rxv_sync_r <= {rxv_sync_r[0], rx_page_valid};
            rxw_s1_r <= rx_page_word;
            rxw_s2_r <= rxw_s1_r;
            taken_prev_r <= taken_sync_r[1];
            rxv_prev_r <= rxv_sync_r[1];
        end
    end

    wire page_arrive = rxv_sync_r[1] & ~rxv_prev_r;
    wire page_sent = taken_sync_r[1] & ~taken_prev_r;

    //==========================================================
    // Register decode
    // Strobe qualified by one register offset
    function automatic logic addr_hit(input logic strobe, input logic [4:0] addr, input logic [4:0] offset);
        return strobe && (addr == offset);
    endfunction

    wire wr_np_tx = addr_hit(reg_write, reg_addr, `ANXP_OFF_NP_TX);
    wire wr_ext = addr_hit(reg_write, reg_addr, `ANXP_OFF_EXT_CTL);
    wire wr_mask = addr_hit(reg_write, reg_addr, `ANXP_OFF_IRQ_MASK);
    wire rd_exp = addr_hit(reg_read, reg_addr, `ANXP_OFF_EXPANSION);
    wire rd_sts = addr_hit(reg_read, reg_addr, `ANXP_OFF_IRQ_STS);

    //==========================================================
    // Registers
    logic [15:0] np_tx_r;
    logic toggle_r;
    logic [15:0] received_page_word_r;
    logic [15:0] ext_ctl_r;
    logic page_rx_flag_r;
    anxp_irq_t irq_sts_r;
    anxp_irq_t irq_mask_r;
    logic [15:0] reg_rdata_r;
    logic [15:0] rdata_nxt;

    wire [15:0] expansion = {9'h000, 1'b1, 1'b1, 3'h0, page_rx_flag_r, able_sync_r[1]};
    wire [15:0] np_tx_view = {np_tx_r[15:12], toggle_r, np_tx_r[10:0]};
    wire anxp_irq_t sts_set = '{page_received: page_arrive, tx_page_taken: page_sent};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            np_tx_r <= `ANXP_RST_NP_TX;
            toggle_r <= 1'b0;
            received_page_word_r <= `ANXP_RST_RECEIVED_PAGE_WORD;
            ext_ctl_r <= `ANXP_RST_EXT_CTL;
            page_rx_flag_r <= 1'b0;
            irq_sts_r <= '0;
            irq_mask_r <= '0;
            reg_rdata_r <= 16'h0000;
        end else begin
            if (wr_np_tx)
                np_tx_r <= {reg_wdata[15], 1'b0, reg_wdata[13:0]};
            if (page_sent)
                toggle_r <= ~toggle_r;
            if (page_arrive)
                received_page_word_r <= rxw_s2_r;
            if (wr_ext)
                ext_ctl_r <= reg_wdata & `ANXP_EXT_CTL_MASK;
            if (page_arrive)
                page_rx_flag_r <= 1'b1;
            else if (rd_exp)
                page_rx_flag_r <= 1'b0;
            irq_sts_r <= sts_set | (rd_sts ? 2'h0 : irq_sts_r);
            if (wr_mask)
                irq_mask_r <= reg_wdata[1:0];
            reg_rdata_r <= rdata_nxt;
        end
    end

    //==========================================================
    // Read data, one cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_read) begin
            case (reg_addr)
                `ANXP_OFF_EXPANSION: rdata_nxt = expansion;
                `ANXP_OFF_NP_TX: rdata_nxt = np_tx_view;
                `ANXP_OFF_RECEIVED_PAGE_WORD: rdata_nxt = received_page_word_r;
                `ANXP_OFF_EXT_CTL: rdata_nxt = ext_ctl_r;
                `ANXP_OFF_IRQ_STS: rdata_nxt = {14'h0, irq_sts_r};
                `ANXP_OFF_IRQ_MASK: rdata_nxt = {14'h0, irq_mask_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign tx_page_word = np_tx_view;
    assign irq = |(irq_sts_r & irq_mask_r);

    //==========================================================
    // Checks
    property p_page_flag;
        @(posedge clk) disable iff (!resetn) page_arrive |=> page_rx_flag_r;
    endproperty
    a_page_flag: assert property (p_page_flag) else $error("page flag not set");

    property p_able;
        @(posedge clk) disable iff (!resetn) rd_exp |=> reg_rdata[0] == $past(able_sync_r[1]);
    endproperty
    a_able: assert property (p_able) else $error("capable bit wrong");

    property p_toggle;
        @(posedge clk) disable iff (!resetn) page_sent |=> tx_page_word[11] != $past(tx_page_word[11]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not flipped");

    property p_rx_read;
        @(posedge clk) disable iff (!resetn)
            reg_read && reg_addr == `ANXP_OFF_RECEIVED_PAGE_WORD |=> reg_rdata == $past(received_page_word_r);
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("received page read wrong");

    property p_rx_ro;
        @(posedge clk) disable iff (!resetn) !page_arrive |=> $stable(received_page_word_r);
    endproperty
    a_rx_ro: assert property (p_rx_ro) else $error("received page changed");

    property p_store_sel;
        @(posedge clk) disable iff (!resetn) rd_exp |=> reg_rdata[5] && reg_rdata[6];
    endproperty
    a_store_sel: assert property (p_store_sel) else $error("store select wrong");

    property p_rsvd;
        @(posedge clk) disable iff (!resetn) wr_np_tx |=> !np_tx_r[14] && np_tx_r[13] == $past(reg_wdata[13]);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("transmit write wrong");

    property p_irq;
        @(posedge clk) disable iff (!resetn) page_arrive && irq_mask_r[1] && !wr_mask |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_reset_tx;
        @(posedge clk) $rose(resetn) |-> np_tx_r == `ANXP_RST_NP_TX || wr_np_tx;
    endproperty
    a_reset_tx: assert property (p_reset_tx) else $error("transmit reset value");

    property p_flag_clear;
        @(posedge clk) disable iff (!resetn) rd_exp && !page_arrive |=> !page_rx_flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("page flag not cleared");

    property p_rdata_idle;
        @(posedge clk) disable iff (!resetn) !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    property p_sts_set;
        @(posedge clk) disable iff (!resetn) page_arrive |=> irq_sts_r.page_received;
    endproperty
    a_sts_set: assert property (p_sts_set) else $error("page status not set");

    property p_sts_clear;
        @(posedge clk) disable iff (!resetn) rd_sts && !page_arrive && !page_sent |=> irq_sts_r == 2'h0;
    endproperty
    a_sts_clear: assert property (p_sts_clear) else $error("status not cleared by read");

    // Arrival step, then the captured word one cycle later
    sequence s_arrive;
        page_arrive;
    endsequence

    sequence s_captured;
        received_page_word_r == $past(rxw_s2_r);
    endsequence

    property p_capture;
        @(posedge clk) disable iff (!resetn) s_arrive |=> s_captured;
    endproperty
    a_capture: assert property (p_capture) else $error("received page not captured");

endmodule

// *** verif/anxp_link_partner.sv ***
// Link partner model that sends next pages and takes local pages
// ==========================================================
// Partner side
module anxp_link_partner (
    input wire logic clk,
    output logic rx_page_valid,
    output logic [15:0] rx_page_word,
    output logic partner_negotiation_capable,
    output logic tx_page_taken
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rx_page_valid = 1'b0;
        rx_page_word = 16'h0000;
        partner_negotiation_capable = 1'b0;
        tx_page_taken = 1'b0;
    end
    task automatic set_cap(input logic c);
        partner_negotiation_capable <= c;
    endtask
    // Whole 16-bit page held around the valid edge, then the line shows no stale value
    task automatic send_page(input logic [15:0] w);
        rx_page_word <= w;
        repeat (3) @(posedge clk);
        rx_page_valid <= 1'b1;
        repeat (4) @(posedge clk);
        rx_page_valid <= 1'b0;
        repeat (3) @(posedge clk);
        rx_page_word <= ~w;
    endtask
    task automatic take_page;
        tx_page_taken <= 1'b1;
        repeat (4) @(posedge clk);
        tx_page_taken <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// *** verif/tb_top.sv ***
// Testbench of the next-page exchange registers
// ==========================================================
// Bench
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic resetn, reg_write, reg_read, irq;
    logic rx_page_valid, partner_negotiation_capable, tx_page_taken;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rx_page_word, tx_page_word;
    logic [15:0] tx_words [3] = '{16'hB7FF, 16'h0000, 16'h2001};
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    anxp_next_page u_anxp_next_page (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .rx_page_valid, .rx_page_word, .partner_negotiation_capable, .tx_page_taken, .tx_page_word, .irq);
    anxp_link_partner u_anxp_link_partner (.clk, .rx_page_valid, .rx_page_word, .partner_negotiation_capable,
        .tx_page_taken);
    task automatic close_out;
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), e, reg_rdata);
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            close_out;
        end
    end
    initial begin
        resetn = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk("tx word", 16'h2001, tx_page_word);
        rd(5'h07, 16'h2001);
        rd(5'h08, 16'h0000);
        rd(5'h06, 16'h0060);
        u_anxp_link_partner.set_cap(1'b1);
        repeat (4) @(posedge clk);
        rd(5'h06, 16'h0061);
        wr(5'h1F, 16'h0002);
        u_anxp_link_partner.send_page(16'hA5C3);
        chk("irq", 16'h0001, {15'h0000, irq});
        rd(5'h06, 16'h0063);
        rd(5'h06, 16'h0061);
        rd(5'h08, 16'hA5C3);
        wr(5'h08, 16'h1234);
        rd(5'h08, 16'hA5C3);
        rd(5'h02, 16'h0000);
        rd(5'h1E, 16'h0002);
        chk("irq", 16'h0000, {15'h0000, irq});
        rd(5'h1E, 16'h0000);
        foreach (tx_words[i]) begin
            wr(5'h07, tx_words[i] | 16'h0800);
            rd(5'h07, tx_words[i]);
            chk("tx word", tx_words[i], tx_page_word);
        end
        u_anxp_link_partner.take_page();
        chk("tx word", 16'h2801, tx_page_word);
        u_anxp_link_partner.take_page();
        chk("tx word", 16'h2001, tx_page_word);
        chk("irq", 16'h0000, {15'h0000, irq});
        rd(5'h1E, 16'h0001);
        wr(5'h0D, 16'hFFFF);
        rd(5'h0D, 16'hC01F);
        rd(5'h1F, 16'h0002);
        wr(5'h1F, 16'h0003);
        u_anxp_link_partner.take_page();
        chk("irq", 16'h0001, {15'h0000, irq});
        chk("tx word", 16'h2801, tx_page_word);
        rd(5'h1E, 16'h0001);
        chk("irq", 16'h0000, {15'h0000, irq});
        close_out;
    end
endmodule
